// ==== logic/srps_map.svh ====
// Purpose: Register offsets, field positions and reset values of the receive port status bank.
// Assumes: Eight-bit registers on the local register port of the serial control interface.
// Notes:   Definitions only.
`ifndef SRPS_MAP_SVH
`define SRPS_MAP_SVH

`define SRPS_PORT_SEL_ADDR     8'h4C
`define SRPS_STATUS_FIRST_ADDR 8'h4D
`define SRPS_STATUS_SECOND_ADDR 8'h4E

// Port select register fields.
`define SRPS_SEL_PHYS_BIT      6
`define SRPS_SEL_READ_BIT      4
`define SRPS_SEL_WR1_BIT       1
`define SRPS_SEL_WR0_BIT       0
`define SRPS_SEL_RESET         8'h00

// First status register fields.
`define SRPS_S1_PORT_BIT       6
`define SRPS_S1_CRC_BIT        5
`define SRPS_S1_LOCKCHG_BIT    4
`define SRPS_S1_SEQ_BIT        3
`define SRPS_S1_PARITY_BIT     2
`define SRPS_S1_PASS_BIT       1
`define SRPS_S1_LOCK_BIT       0

// Second status register fields.
`define SRPS_S2_UNSTABLE_BIT   7
`define SRPS_S2_LENCHG_BIT     6
`define SRPS_S2_CODING_BIT     5
`define SRPS_S2_BUFFER_BIT     4
`define SRPS_S2_CAMERA_BIT     3
`define SRPS_S2_FREQ_BIT       2
`define SRPS_S2_CABLE_BIT      1
`define SRPS_S2_CNTCHG_BIT     0

`define SRPS_FLAG_RESET        1'b0
`define SRPS_RDATA_RESET       8'h00
`define SRPS_UNMAPPED_DATA     8'h00

`endif

// ==== logic/srps_pkg.sv ====
// Purpose: Types shared by the receive port status bank.
// Assumes: Link-side sources present one struct of events and one of levels per port.
// Notes:   Field order of the structs is the crossing order.
package srps_pkg;

  // One-cycle event pulses raised by the link-side logic.
  typedef struct packed {
    logic crc_err;
    logic seq_err;
    logic coding_err;
    logic buffer_overflow;
    logic row_width_changed;
    logic row_count_changed;
    logic row_width_unstable;
  } srps_evt_t;

  // Live levels raised by the link-side logic.
  typedef struct packed {
    logic receiver_locked;
    logic pass;
    logic parity_over_limit;
    logic camera_err;
    logic freq_stable;
    logic cable_fault;
  } srps_lvl_t;

  typedef logic [7:0] srps_byte_t;

endpackage

// ==== logic/srps_link_cross.sv ====
// Purpose: Carries one port's link-domain events and levels into the system clock domain.
// Assumes: Events are one link-clock-cycle pulses; levels are steady for several cycles.
// Notes:   Events use toggle crossing, levels a two-flop synchroniser.
`timescale 1ns/1ps
module srps_link_cross
  import srps_pkg::*;
#(
  parameter int EW = $bits(srps_evt_t),
  parameter int LW = $bits(srps_lvl_t)
)
(
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          link_clk_i,
  input  wire logic [EW-1:0] evt_link_i,
  input  wire logic [LW-1:0] lvl_link_i,
  output logic      [EW-1:0] evt_pulse_o,
  output logic      [LW-1:0] lvl_sync_o
);

  logic          link_rst_meta_ff;
  logic          link_rst_ff;
  logic [EW-1:0] tog_ff;
  logic [EW-1:0] tog_meta_ff;
  logic [EW-1:0] tog_sync_ff;
  logic [EW-1:0] tog_prev_ff;
  logic [LW-1:0] lvl_meta_ff;
  logic [LW-1:0] lvl_sync_ff;

  // Reset reaches the link domain through its own synchroniser.
  always_ff @(posedge link_clk_i)
  begin
    link_rst_meta_ff <= rst_i;
    link_rst_ff      <= link_rst_meta_ff;
  end

  // Each event flips its toggle, so a pulse survives any clock ratio.
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst_ff)
    begin
      tog_ff <= '0;
    end
    else
    begin
      tog_ff <= tog_ff ^ evt_link_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tog_meta_ff <= '0;
      tog_sync_ff <= '0;
      tog_prev_ff <= '0;
    end
    else
    begin
      tog_meta_ff <= tog_ff;
      tog_sync_ff <= tog_meta_ff;
      tog_prev_ff <= tog_sync_ff;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      lvl_meta_ff <= '0;
      lvl_sync_ff <= '0;
    end
    else
    begin
      lvl_meta_ff <= lvl_link_i;
      lvl_sync_ff <= lvl_meta_ff;
    end
  end

  assign evt_pulse_o = tog_sync_ff ^ tog_prev_ff;
  assign lvl_sync_o  = lvl_sync_ff;

endmodule // srps_link_cross

// ==== logic/srps_status_bank.sv ====
// Purpose: Per receive port status register pair with port select, read over the local port.
// Assumes: The serial control interface presents one-cycle read and write strobes.
// Notes:   Clear-on-read flags clear only in the selected port's copy.
`timescale 1ns/1ps
`include "srps_map.svh"
module srps_status_bank
  import srps_pkg::*;
#(
  parameter int NPORT = 2
)
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       link_clk_i [NPORT],
  input  wire srps_evt_t  evt_link_i [NPORT],
  input  wire srps_lvl_t  lvl_link_i [NPORT],
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_wr_i,
  input  wire srps_byte_t reg_wdata_i,
  output srps_byte_t      reg_rdata_o,
  output logic            reg_rvalid_o,
  output logic            read_port_o,
  output logic [1:0]      write_en_o
);

  srps_evt_t  evt_sys   [NPORT];
  srps_lvl_t  lvl_sys   [NPORT];
  logic       lock_prev_ff [NPORT];
  srps_byte_t sts1_flags_ff [NPORT];
  srps_byte_t sts2_flags_ff [NPORT];
  srps_byte_t sts1_view [NPORT];
  srps_byte_t sts2_view [NPORT];
  logic       read_port_ff;
  logic [1:0] write_en_ff;
  srps_byte_t rdata_ff;
  srps_byte_t nxt_rdata;
  logic       rvalid_ff;
  logic       rd_first;
  logic       rd_second;

  // A literal cannot be bit-selected, so the reset byte is held as a constant first.
  localparam srps_byte_t SEL_RESET_VAL = `SRPS_SEL_RESET;

  assign rd_first  = reg_rd_i && (reg_addr_i == `SRPS_STATUS_FIRST_ADDR);
  assign rd_second = reg_rd_i && (reg_addr_i == `SRPS_STATUS_SECOND_ADDR);

  // Port select register; status registers ignore writes.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      read_port_ff <= SEL_RESET_VAL[`SRPS_SEL_READ_BIT];
      write_en_ff  <= SEL_RESET_VAL[`SRPS_SEL_WR1_BIT:`SRPS_SEL_WR0_BIT];
    end
    else if (reg_wr_i && (reg_addr_i == `SRPS_PORT_SEL_ADDR))
    begin
      read_port_ff <= reg_wdata_i[`SRPS_SEL_READ_BIT];
      write_en_ff  <= reg_wdata_i[`SRPS_SEL_WR1_BIT:`SRPS_SEL_WR0_BIT];
    end
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic sel_hit;
    logic lock_change;
    logic clr1;
    logic clr2;

    srps_link_cross u_cross (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .link_clk_i  (link_clk_i[p]),
      .evt_link_i  (evt_link_i[p]),
      .lvl_link_i  (lvl_link_i[p]),
      .evt_pulse_o (evt_sys[p]),
      .lvl_sync_o  (lvl_sys[p])
    );

    assign sel_hit     = (read_port_ff == 1'(p));
    assign clr1        = rd_first && sel_hit;
    assign clr2        = rd_second && sel_hit;
    assign lock_change = lvl_sys[p].receiver_locked ^ lock_prev_ff[p];

    always_ff @(posedge clock_i)
    begin
      if (rst_i)
      begin
        lock_prev_ff[p] <= `SRPS_FLAG_RESET;
      end
      else
      begin
        lock_prev_ff[p] <= lvl_sys[p].receiver_locked;
      end
    end

    // A set arriving with the clearing read wins, so no event is lost.
    always_ff @(posedge clock_i)
    begin
      if (rst_i)
      begin
        sts1_flags_ff[p] <= '0;
      end
      else
      begin
        sts1_flags_ff[p][`SRPS_S1_CRC_BIT] <= evt_sys[p].crc_err ||
          (sts1_flags_ff[p][`SRPS_S1_CRC_BIT] && !clr1);
        sts1_flags_ff[p][`SRPS_S1_LOCKCHG_BIT] <= lock_change ||
          (sts1_flags_ff[p][`SRPS_S1_LOCKCHG_BIT] && !clr1);
        sts1_flags_ff[p][`SRPS_S1_SEQ_BIT] <= evt_sys[p].seq_err ||
          (sts1_flags_ff[p][`SRPS_S1_SEQ_BIT] && !clr1);
      end
    end

    // The coding error only arrives while lock holds; the link error limit must exceed one.
    always_ff @(posedge clock_i)
    begin
      if (rst_i)
      begin
        sts2_flags_ff[p] <= '0;
      end
      else
      begin
        sts2_flags_ff[p][`SRPS_S2_UNSTABLE_BIT] <= evt_sys[p].row_width_unstable ||
          (sts2_flags_ff[p][`SRPS_S2_UNSTABLE_BIT] && !clr2);
        sts2_flags_ff[p][`SRPS_S2_LENCHG_BIT] <= evt_sys[p].row_width_changed ||
          (sts2_flags_ff[p][`SRPS_S2_LENCHG_BIT] && !clr2);
        sts2_flags_ff[p][`SRPS_S2_CODING_BIT] <= evt_sys[p].coding_err ||
          (sts2_flags_ff[p][`SRPS_S2_CODING_BIT] && !clr2);
        sts2_flags_ff[p][`SRPS_S2_BUFFER_BIT] <= evt_sys[p].buffer_overflow ||
          (sts2_flags_ff[p][`SRPS_S2_BUFFER_BIT] && !clr2);
        sts2_flags_ff[p][`SRPS_S2_CNTCHG_BIT] <= evt_sys[p].row_count_changed ||
          (sts2_flags_ff[p][`SRPS_S2_CNTCHG_BIT] && !clr2);
      end
    end

    // Live levels merge with the sticky flags; reserved bit 7 of the first status register reads zero.
    always_comb
    begin
      sts1_view[p] = '0;
      sts1_view[p][`SRPS_S1_PORT_BIT]    = read_port_ff;
      sts1_view[p][`SRPS_S1_CRC_BIT]     = sts1_flags_ff[p][`SRPS_S1_CRC_BIT];
      sts1_view[p][`SRPS_S1_LOCKCHG_BIT] = sts1_flags_ff[p][`SRPS_S1_LOCKCHG_BIT];
      sts1_view[p][`SRPS_S1_SEQ_BIT]     = sts1_flags_ff[p][`SRPS_S1_SEQ_BIT];
      sts1_view[p][`SRPS_S1_PARITY_BIT]  = lvl_sys[p].parity_over_limit;
      sts1_view[p][`SRPS_S1_PASS_BIT]    = lvl_sys[p].pass;
      sts1_view[p][`SRPS_S1_LOCK_BIT]    = lvl_sys[p].receiver_locked;
      sts2_view[p] = sts2_flags_ff[p];
      sts2_view[p][`SRPS_S2_CAMERA_BIT]  = lvl_sys[p].camera_err;
      sts2_view[p][`SRPS_S2_FREQ_BIT]    = lvl_sys[p].freq_stable;
      sts2_view[p][`SRPS_S2_CABLE_BIT]   = lvl_sys[p].cable_fault;
    end
  end

  // Read mux; status reads return the port chosen by the read port select bit.
  always_comb
  begin
    nxt_rdata = `SRPS_UNMAPPED_DATA;
    unique case (reg_addr_i)
      `SRPS_PORT_SEL_ADDR:
      begin
        nxt_rdata[`SRPS_SEL_READ_BIT] = read_port_ff;
        nxt_rdata[`SRPS_SEL_WR1_BIT]  = write_en_ff[1];
        nxt_rdata[`SRPS_SEL_WR0_BIT]  = write_en_ff[0];
      end
      `SRPS_STATUS_FIRST_ADDR:  nxt_rdata = sts1_view[read_port_ff];
      `SRPS_STATUS_SECOND_ADDR: nxt_rdata = sts2_view[read_port_ff];
      default:                  nxt_rdata = `SRPS_UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rdata_ff  <= `SRPS_RDATA_RESET;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata_o  = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign read_port_o  = read_port_ff;
  assign write_en_o   = write_en_ff;

endmodule // srps_status_bank

// ==== sim/srps_props.sv ====
// Purpose: Port checks of the receive port status bank.
// Assumes: Register side runs on clock_i alone.
// Notes:   Link inputs are seen here but checked by the bench.
`timescale 1ns/1ps
module srps_props
  import srps_pkg::*;
#(
  parameter int NPORT = 2
)
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       link_clk_i [NPORT],
  input  wire srps_evt_t  evt_link_i [NPORT],
  input  wire srps_lvl_t  lvl_link_i [NPORT],
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_wr_i,
  input  wire srps_byte_t reg_wdata_i,
  input  wire srps_byte_t reg_rdata_o,
  input  wire logic       reg_rvalid_o,
  input  wire logic       read_port_o,
  input  wire logic [1:0] write_en_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire sel_wr = reg_wr_i && reg_addr_i == 8'h4C;
  wire sel_rd = reg_rd_i && reg_addr_i == 8'h4C && !reg_wr_i;
  wire s1_rd  = reg_rd_i && reg_addr_i == 8'h4D;
  property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_norv; !reg_rd_i |=> !reg_rvalid_o; endproperty
  a_norv: assert property (p_norv) else $error("answer without read");
  property p_num; s1_rd && !reg_wr_i |=> reg_rdata_o[6] == $past(read_port_o); endproperty
  a_num: assert property (p_num) else $error("port number wrong");
  property p_rsv; s1_rd |=> !reg_rdata_o[7]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_sel;
    sel_wr |=> read_port_o == $past(reg_wdata_i[4]) && write_en_o == $past(reg_wdata_i[1:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("select not taken");
  property p_keep; !sel_wr |=> $stable(read_port_o) && $stable(write_en_o); endproperty
  a_keep: assert property (p_keep) else $error("select moved");
  property p_selrd; sel_rd |=> reg_rdata_o == {3'h0, read_port_o, 2'h0, write_en_o}; endproperty
  a_selrd: assert property (p_selrd) else $error("select readback wrong");
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unm;
    reg_rd_i && !(reg_addr_i inside {[8'h4C:8'h4E]}) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_s1: cover property (s1_rd);
  c_sel: cover property (sel_wr);
  c_s2: cover property (reg_rd_i && reg_addr_i == 8'h4E);
endmodule // srps_props

// ==== sim/srps_far_model.sv ====
// Purpose: Far-side link source with link clocks, event pulses and levels.
// Assumes: Embedded link clocks run free at 125 ns with unrelated phases.
// Notes:   Driven only through its tasks.
`timescale 1ns/1ps
module srps_far_model
  import srps_pkg::*;
(
  output logic      link_clk_o [2],
  output srps_evt_t evt_o      [2],
  output srps_lvl_t lvl_o      [2]
);
  initial
  begin
    link_clk_o[0] = 1'b0;
    evt_o = '{default: '0};
    lvl_o = '{default: '0};
    #17.3;
    forever #62.5 link_clk_o[0] = ~link_clk_o[0];
  end
  initial
  begin
    link_clk_o[1] = 1'b0;
    #41.9;
    forever #62.5 link_clk_o[1] = ~link_clk_o[1];
  end
  // One link cycle per event, so each pulse flips the crossing toggle once.
  // Values change on the falling link edge, away from the rising link edge that samples the events; clock_i samples the levels.
  task automatic pulse(input int p, input srps_evt_t e);
    @(negedge link_clk_o[p]);
    evt_o[p] = e;
    @(negedge link_clk_o[p]);
    evt_o[p] = '0;
  endtask
  task automatic level(input int p, input srps_lvl_t l);
    @(negedge link_clk_o[p]);
    lvl_o[p] = l;
  endtask
endmodule // srps_far_model

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the receive port status bank.
// Assumes: The far model supplies link clocks, events and levels.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/1ps
module tb_top;
  import srps_pkg::*;
  logic       clock_i;
  logic       rst_i;
  logic       rd;
  logic       wr;
  logic [7:0] addr;
  srps_byte_t wdata;
  srps_byte_t rdata;
  logic       rvalid;
  logic       rport;
  logic [1:0] wen;
  logic       lclk [2];
  srps_evt_t  evt  [2];
  srps_lvl_t  lvl  [2];
  int         error_cnt = 0;
  int         compares = 0;
  logic [7:0] ea [7] = '{8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'h4D, 8'h4D};
  srps_byte_t eb [7] = '{8'h80, 8'h01, 8'h40, 8'h10, 8'h20, 8'h08, 8'h20};
  srps_far_model far (.link_clk_o(lclk), .evt_o(evt), .lvl_o(lvl));
  srps_status_bank #(.NPORT(2)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .link_clk_i(lclk), .evt_link_i(evt),
    .lvl_link_i(lvl), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .read_port_o(rport), .write_en_o(wen));
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input string n, input srps_byte_t e, input srps_byte_t g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input srps_byte_t d);
    @(negedge clock_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clock_i);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input srps_byte_t e, input string n);
    @(negedge clock_i);
    rd = 1'b1;
    addr = a;
    @(negedge clock_i);
    rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk(n, e, rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A stalled link clock would otherwise hang the run, so time is bounded here.
  initial
  begin
    repeat (40000) @(posedge clock_i);
    error_cnt++;
    $display("[ERR] run time expected done seen timeout");
    final_report();
  end
  initial
  begin
    rst_i = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    // Reset spans link edges too, since the link side synchronises it.
    repeat (4) @(posedge lclk[0]);
    @(negedge clock_i);
    rst_i = 1'b0;
    idle(60);
    rd_reg(8'h4C, 8'h00, "select");
    rd_reg(8'h4D, 8'h00, "status1");
    rd_reg(8'h4E, 8'h00, "status2");
    rd_reg(8'h40, 8'h00, "unmapped");
    wr_reg(8'h4D, 8'hFF);
    rd_reg(8'h4D, 8'h00, "status1 ro");
    for (int i = 0; i < 7; i++)
    begin
      far.pulse(0, srps_evt_t'(7'h01 << i));
      idle(40);
      rd_reg(ea[i], eb[i], "event set");
      rd_reg(ea[i], 8'h00, "event clear");
    end
    far.pulse(0, srps_evt_t'(7'h40));
    idle(40);
    wr_reg(8'h4C, 8'h10);
    chk("select outputs", 8'h10, {3'h0, rport, 2'h0, wen});
    rd_reg(8'h4D, 8'h40, "port1 status1");
    far.pulse(1, srps_evt_t'(7'h20));
    idle(40);
    rd_reg(8'h4D, 8'h48, "port1 seq");
    rd_reg(8'h4D, 8'h40, "port1 clear");
    wr_reg(8'h4C, 8'h03);
    chk("select outputs", 8'h03, {3'h0, rport, 2'h0, wen});
    rd_reg(8'h4C, 8'h03, "select");
    rd_reg(8'h4D, 8'h20, "port0 kept");
    rd_reg(8'h4D, 8'h00, "port0 clear");
    far.level(0, '1);
    idle(40);
    rd_reg(8'h4D, 8'h17, "levels up");
    rd_reg(8'h4D, 8'h07, "levels kept");
    rd_reg(8'h4E, 8'h0E, "levels s2");
    far.level(0, '0);
    idle(40);
    rd_reg(8'h4D, 8'h10, "levels down");
    rd_reg(8'h4E, 8'h00, "levels s2 down");
    final_report();
  end
endmodule // tb_top
bind srps_status_bank srps_props #(.NPORT(NPORT)) u_props (
  .clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .evt_link_i(evt_link_i),
  .lvl_link_i(lvl_link_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .read_port_o(read_port_o), .write_en_o(write_en_o));
